// *** src/pss_top.v ***
// Power sequencer and supervisor: rail enables, boost gate, power good, protection.
// Assumes analog comparators and shutdown pins arrive asynchronously; APB from same clock.
`timescale 1ns/1ps
`include "pss_defines.vh"

module pss_top #(
    parameter MAIN_DIV = (`PSS_MAIN_PERIOD_PS + `PSS_CLK_PERIOD_PS / 2) / `PSS_CLK_PERIOD_PS
) (
    input wire clock,
    input wire resetn,
    input wire ce,
    // Shutdown inputs from the system controller
    input wire master_shutdown_n,
    input wire main5_shutdown_n,
    input wire main3_shutdown_n,
    // Comparators: bit0 always5, bit1 main5, bit2 main3, bit3 boost12
    input wire [3:0] rail_in_window,
    input wire [3:0] rail_under75,
    // Overvoltage: bit0 main5, bit1 main3
    input wire [1:0] main_over115,
    // Soft start finished: bit0 main5, bit1 main3
    input wire [1:0] soft_start_done,
    input wire ramp_above_err,
    input wire boost_sense_in,
    input wire temp_over150,
    input wire temp_below125,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Rail controls
    output reg always_en,
    output reg ldo5_en,
    output reg handover_sw,
    output reg main5_en,
    output reg main3_en,
    output reg boost_en,
    output reg boost_gate,
    output reg main5_crowbar,
    output reg main3_crowbar,
    output reg power_good_out,
    output reg main_clk_tick
);

    localparam NSYNC = 19;
    localparam ST_OFF = 2'b00;
    localparam ST_RUN = 2'b01;
    localparam ST_UV = 2'b10;
    localparam ST_HOT = 2'b11;

    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] s1_q;
    reg [NSYNC-1:0] s2_q;
    reg [NSYNC-1:0] s3_q;
    reg [NSYNC-1:0] in_q;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [9:0] tick_cnt_q;
    reg [1:0] div_q;
    reg pulse_q;
    reg [1:0] ctrl_q;
    reg [3:0] fault_q;
    reg [3:0] fault_set;

    wire sys_on;
    wire m5_n;
    wire m3_n;
    wire [3:0] win;
    wire [3:0] u75;
    wire [1:0] ov;
    wire [1:0] ssd;
    wire ramp_hi;
    wire sense_tied;
    wire hot;
    wire cool;
    wire tick;
    wire pulse_fall;
    wire [3:0] monitored;
    wire ss_complete;
    wire uv_trip;
    wire apb_write;

    assign raw_in = {temp_below125, temp_over150, boost_sense_in, ramp_above_err,
                     soft_start_done, main_over115, rail_under75, rail_in_window,
                     main3_shutdown_n, main5_shutdown_n, master_shutdown_n};

    // Three-flop synchronisers; value accepted when second and third agree
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            always @(posedge clock)
            begin
                if (!resetn)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    in_q[gi] <= 1'b0;
                end
                else if (ce)
                begin
                    s1_q[gi] <= raw_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi])
                        in_q[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate

    // Field views of the synchronised inputs
    assign sys_on = in_q[0];
    assign m5_n = in_q[1];
    assign m3_n = in_q[2];
    assign win = in_q[6:3];
    assign u75 = in_q[10:7];
    assign ov = in_q[12:11];
    assign ssd = in_q[14:13];
    assign ramp_hi = in_q[15];
    assign sense_tied = in_q[16];
    assign hot = in_q[17];
    assign cool = in_q[18];

    // Main clock tick at 300 kHz
    assign tick = (tick_cnt_q == MAIN_DIV - 1);

    always @(posedge clock)
    begin
        if (!resetn)
            tick_cnt_q <= 10'h000;
        else if (ce)
            tick_cnt_q <= tick ? 10'h000 : tick_cnt_q + 10'h001;
    end

    // Divide-by-three boost clock, pulse one main period wide
    assign pulse_fall = tick && (div_q == 2'h0);

    always @(posedge clock)
    begin
        if (!resetn)
        begin
            div_q <= 2'h0;
            pulse_q <= 1'b0;
        end
        else if (ce && tick)
        begin
            div_q <= (div_q == `PSS_BOOST_DIV - 1) ? 2'h0 : div_q + 2'h1;
            pulse_q <= (div_q == `PSS_BOOST_DIV - 1);
        end
    end

    // Supervised rails: every enabled rail, the always-on rail included
    assign monitored = {boost_en, main3_en, main5_en, always_en};
    assign ss_complete = (~main5_en | ssd[0]) & (~main3_en | ssd[1]) & always_en;
    assign uv_trip = ctrl_q[`PSS_CTRL_UV_EN] & ss_complete & (|(u75 & monitored));

    // Sequencer state machine
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_OFF:
            begin
                if (hot)
                    state_d = ST_HOT;
                else if (sys_on)
                    state_d = ST_RUN;
            end
            ST_RUN:
            begin
                if (hot)
                    state_d = ST_HOT;
                else if (!sys_on)
                    state_d = ST_OFF;
                else if (uv_trip)
                    state_d = ST_UV;
            end
            ST_UV:
            begin
                if (!sys_on)
                    state_d = ST_OFF;
            end
            default:
            begin
                if (cool && !hot)
                    state_d = ST_OFF;
            end
        endcase
    end

    always @(posedge clock)
    begin
        if (!resetn)
            state_q <= ST_OFF;
        else if (ce)
            state_q <= state_d;
    end

    // Rail enables, handover switch and power good
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            always_en <= 1'b0;
            ldo5_en <= 1'b0;
            handover_sw <= 1'b0;
            main5_en <= 1'b0;
            main3_en <= 1'b0;
            boost_en <= 1'b0;
            power_good_out <= 1'b0;
        end
        else if (ce)
        begin
            always_en <= (state_q == ST_RUN) && (state_d == ST_RUN);
            // Mains wait for always-on rails; standby when both main inputs low
            main5_en <= always_en && (state_d == ST_RUN) && m5_n;
            main3_en <= always_en && (state_d == ST_RUN) && m3_n;
            boost_en <= always_en && (state_d == ST_RUN) && m5_n && !sense_tied
                        && !ctrl_q[`PSS_CTRL_BOOST_OFF];
            handover_sw <= main5_en && !u75[1] && (state_d == ST_RUN);
            ldo5_en <= (state_d == ST_RUN) && !(main5_en && !u75[1]);
            power_good_out <= (state_q == ST_RUN) && (state_d == ST_RUN) && ss_complete
                              && ((win & monitored) == monitored);
        end
    end

    // Boost latch: set by ramp comparator inside pulse, reset at pulse end
    always @(posedge clock)
    begin
        if (!resetn)
            boost_gate <= 1'b0;
        else if (ce)
        begin
            if (!boost_en || pulse_fall || !pulse_q)
                boost_gate <= 1'b0;
            else if (ramp_hi)
                boost_gate <= 1'b1;
        end
    end

    // Soft crowbar on main rail overvoltage, held until back in window
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            main5_crowbar <= 1'b0;
            main3_crowbar <= 1'b0;
        end
        else if (ce)
        begin
            if (!main5_en)
                main5_crowbar <= 1'b0;
            else if (ov[0])
                main5_crowbar <= 1'b1;
            else if (win[1])
                main5_crowbar <= 1'b0;
            if (!main3_en)
                main3_crowbar <= 1'b0;
            else if (ov[1])
                main3_crowbar <= 1'b1;
            else if (win[2])
                main3_crowbar <= 1'b0;
        end
    end

    // Main clock tick as a one-cycle strobe
    always @(posedge clock)
    begin
        if (!resetn)
            main_clk_tick <= 1'b0;
        else if (ce)
            main_clk_tick <= tick;
    end

    // Sticky fault events
    always @*
    begin
        fault_set = 4'h0;
        fault_set[`PSS_FLT_UV] = (state_q == ST_RUN) && (state_d == ST_UV);
        fault_set[`PSS_FLT_OT] = (state_q != ST_HOT) && (state_d == ST_HOT);
        fault_set[`PSS_FLT_OV5] = main5_en && ov[0];
        fault_set[`PSS_FLT_OV3] = main3_en && ov[1];
    end

    // APB write strobe at the completing access edge
    assign apb_write = psel && penable && pready && pwrite;

    // Control and fault registers; set wins over write-one-to-clear
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            ctrl_q <= `PSS_CTRL_RESET;
            fault_q <= 4'h0;
        end
        else if (ce)
        begin
            if (apb_write && paddr == `PSS_OFF_CTRL)
                ctrl_q <= pwdata[1:0];
            if (apb_write && paddr == `PSS_OFF_FAULT)
                fault_q <= (fault_q & ~pwdata[3:0]) | fault_set;
            else
                fault_q <= fault_q | fault_set;
        end
    end

    // APB answer: one wait-free access phase, data and error set in setup
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (ce)
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable)
            begin
                if (paddr == `PSS_OFF_CTRL)
                    prdata <= {30'h0, ctrl_q};
                else if (paddr == `PSS_OFF_STATUS)
                    prdata <= {16'h0000, state_q, power_good_out, main3_crowbar, main5_crowbar,
                               boost_en, main3_en, main5_en, handover_sw, ldo5_en, always_en,
                               sense_tied, hot, sys_on, m3_n, m5_n};
                else if (paddr == `PSS_OFF_FAULT)
                    prdata <= {28'h0000000, fault_q};
                else
                    pslverr <= 1'b1;
            end
        end
    end

endmodule // pss_top

// *** src/pss_defines.vh ***
// Constants for the power sequencer and supervisor: offsets, fields, resets, timing.
// Assumes a 200 MHz system clock and a 300 kHz main clock derived from it.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// Timing
`define PSS_CLK_PERIOD_PS 5000
`define PSS_MAIN_PERIOD_PS 3333333
`define PSS_BOOST_DIV 3

// Register byte offsets
`define PSS_OFF_CTRL 12'h000
`define PSS_OFF_STATUS 12'h004
`define PSS_OFF_FAULT 12'h008

// Control fields and reset value
`define PSS_CTRL_BOOST_OFF 0
`define PSS_CTRL_UV_EN 1
`define PSS_CTRL_RESET 2'h2

// Fault sticky fields
`define PSS_FLT_UV 0
`define PSS_FLT_OT 1
`define PSS_FLT_OV5 2
`define PSS_FLT_OV3 3

`endif

// *** sim/pss_assertions.sv ***
// Checker for the sequencer top: rail order, boost gate, main tick, reset.
// Assumes it is bound to pss_top and sees only its ports.
`timescale 1ns/1ps
module pss_assertions #(
    parameter MAIN_DIV = 6
) (
    input wire clock,
    input wire resetn,
    input wire main_clk_tick,
    input wire always_en,
    input wire ldo5_en,
    input wire handover_sw,
    input wire main5_en,
    input wire main3_en,
    input wire boost_en,
    input wire boost_gate,
    input wire power_good_out
);
    reg [15:0] gate_run_q;
    reg [15:0] tick_gap_q;
    reg tick_seen_q;
    default clocking cb @(posedge clock);
    endclocking
    // Length of gate-high run and gap since last tick
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            gate_run_q <= 16'h0000;
            tick_gap_q <= 16'h0000;
            tick_seen_q <= 1'b0;
        end
        else
        begin
            gate_run_q <= boost_gate ? gate_run_q + 16'h0001 : 16'h0000;
            tick_gap_q <= main_clk_tick ? 16'h0000 : tick_gap_q + 16'h0001;
            tick_seen_q <= tick_seen_q | main_clk_tick;
        end
    end
    sequence tick_s;
        main_clk_tick ##1 !main_clk_tick;
    endsequence
    rails_off_a: assert property (disable iff (!resetn)
        !always_en |-> !main5_en && !main3_en && !boost_en) else $error("main rail on without always-on");
    main_order_a: assert property (disable iff (!resetn)
        $rose(main5_en) || $rose(main3_en) |-> $past(always_en)) else $error("main rail before always-on");
    boost_pair_a: assert property (disable iff (!resetn)
        boost_en |-> main5_en) else $error("boost on without 5V main");
    handover_a: assert property (disable iff (!resetn)
        handover_sw |-> !ldo5_en) else $error("regulator on with handover closed");
    gate_duty_a: assert property (disable iff (!resetn)
        boost_gate |-> gate_run_q < MAIN_DIV) else $error("boost gate high too long");
    tick_pulse_a: assert property (disable iff (!resetn)
        main_clk_tick |-> tick_s) else $error("main tick wider than one cycle");
    tick_period_a: assert property (disable iff (!resetn)
        main_clk_tick && tick_seen_q |-> tick_gap_q == MAIN_DIV - 1) else $error("main tick period wrong");
    reset_off_a: assert property (disable iff (1'b0)
        !resetn |=> !always_en && !boost_gate && !power_good_out) else $error("output on after reset");
    gate_tick_a: assert property (disable iff (!resetn)
        main_clk_tick |-> !boost_gate) else $error("boost gate high at main tick");
    pg_rails_a: assert property (disable iff (!resetn)
        power_good_out |-> always_en) else $error("power good without always-on rails");
endmodule // pss_assertions

bind pss_top pss_assertions #(.MAIN_DIV(MAIN_DIV)) chk_i (.clock(clock), .resetn(resetn),
    .main_clk_tick(main_clk_tick), .always_en(always_en), .ldo5_en(ldo5_en), .handover_sw(handover_sw),
    .main5_en(main5_en), .main3_en(main3_en), .boost_en(boost_en), .boost_gate(boost_gate),
    .power_good_out(power_good_out));

// *** sim/pss_sysctl_model.sv ***
// System controller model driving the three shutdown levels.
// Assumes the bench hands it a request word; bit2 master, bit1 5V main, bit0 3.3V main.
`timescale 1ns/1ps
module pss_sysctl_model (
    input wire clock,
    input wire [2:0] req,
    output reg master_shutdown_n,
    output reg main5_shutdown_n,
    output reg main3_shutdown_n
);
    initial {master_shutdown_n, main5_shutdown_n, main3_shutdown_n} = 3'h0;
    // Levels change only just after a rising edge
    always @(posedge clock)
    begin
        {master_shutdown_n, main5_shutdown_n, main3_shutdown_n} <= req;
    end
endmodule // pss_sysctl_model

// *** sim/power_sequencer_supervisor_tb_top.sv ***
// Self-checking bench for pss_top: rail table, boost, protection, APB.
// Assumes 200 MHz clock and a main divider shortened to 6.
`timescale 1ns/1ps
module power_sequencer_supervisor_tb_top;
    reg clock = 1'b0;
    reg resetn = 1'b0;
    reg [2:0] req = 3'h0;
    reg [3:0] u75 = 4'h0;
    reg [1:0] ov = 2'h0;
    reg ramp = 1'b0;
    reg sense = 1'b0;
    reg hot = 1'b0;
    reg cool = 1'b1;
    reg [3:0] win = 4'hf;
    reg [1:0] ssd = 2'h3;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [31:0] rd;
    reg [31:0] rnd;
    reg [2:0] s;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, m_n, m5_n, m3_n, aon, ldo, hsw, e5, e3, eb, gate, cb5, cb3, pg;
    integer failures = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer i;
    integer gates;
    always #2.5 clock = ~clock;
    pss_sysctl_model sysctl (.clock(clock), .req(req), .master_shutdown_n(m_n), .main5_shutdown_n(m5_n),
        .main3_shutdown_n(m3_n));
    pss_top #(.MAIN_DIV(6)) uut (.clock(clock), .resetn(resetn), .ce(1'b1), .master_shutdown_n(m_n),
        .main5_shutdown_n(m5_n), .main3_shutdown_n(m3_n), .rail_in_window(win), .rail_under75(u75),
        .main_over115(ov), .soft_start_done(ssd), .ramp_above_err(ramp), .boost_sense_in(sense),
        .temp_over150(hot), .temp_below125(cool), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .always_en(aon), .ldo5_en(ldo), .handover_sw(hsw), .main5_en(e5), .main3_en(e3), .boost_en(eb),
        .boost_gate(gate), .main5_crowbar(cb5), .main3_crowbar(cb3), .power_good_out(pg), .main_clk_tick());
    // Expected steady rails {aon,5V,3V,boost,handover,ldo,pg} for a shutdown word
    function [6:0] rails(input [2:0] w);
        rails = {w[2], w[2] & w[1], w[2] & w[0], w[2] & w[1], w[2] & w[1], w[2] & ~w[1], w[2]};
    endfunction
    task go(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task chk(input [39:0] seen, input [39:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
        begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task report_and_stop;
    begin
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // Cut a hung run short
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    initial
    begin
        rnd = $urandom(44);
        go(2);
        resetn <= 1'b1;
        // Full shutdown table, then random words
        for (i = 0; i < 14; i = i + 1)
        begin
            rnd = $urandom;
            s = (i < 8) ? i[2:0] : rnd[2:0];
            req <= s;
            go(16);
            #1;
            chk({aon, e5, e3, eb, hsw, ldo, pg}, rails(s));
            go(1);
        end
        req <= 3'h7;
        $display("rail table done");
        // Registers: boost off, readback, status, unmapped
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h3);
        go(16);
        #1;
        chk(eb, 1'b0);
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h00c, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        go(16);
        apb(1'b0, 12'h004, 32'h0);
        chk({rd[15:14], rd[5], rd[10]}, 4'b0111);
        sense <= 1'b1;
        go(16);
        #1;
        chk(eb, 1'b0);
        go(1);
        sense <= 1'b0;
        $display("register test done");
        // Random ramp compare drives the boost gate
        gates = 0;
        repeat (300)
        begin
            @(posedge clock);
            rnd = $urandom;
            ramp <= rnd[0];
            gates = gates + gate;
        end
        chk({gates != 0, gates <= 106}, 2'b11);
        $display("boost test done");
        // Overvoltage crowbar set then released
        ov <= 2'h1;
        go(12);
        #1;
        chk({cb5, cb3}, 2'b10);
        go(1);
        ov <= 2'h0;
        go(12);
        #1;
        chk({cb5, cb3}, 2'b00);
        go(1);
        ov <= 2'h2;
        go(12);
        #1;
        chk({cb5, cb3}, 2'b01);
        go(1);
        ov <= 2'h0;
        go(12);
        #1;
        chk({cb5, cb3}, 2'b00);
        $display("crowbar test done");
        // Over-temperature shutdown and automatic restart
        go(1);
        hot <= 1'b1;
        cool <= 1'b0;
        go(12);
        #1;
        chk({aon, e5, e3}, 3'b000);
        go(1);
        hot <= 1'b0;
        cool <= 1'b1;
        go(24);
        #1;
        chk({aon, e5, e3}, 3'b111);
        $display("thermal test done");
        // One-cycle glitch on the thermal input must be ignored
        go(1);
        hot <= 1'b1;
        go(1);
        hot <= 1'b0;
        go(12);
        #1;
        chk(aon, 1'b1);
        // Power good follows window and soft start; no trip before soft start ends
        go(1);
        win <= 4'h7;
        go(12);
        #1;
        chk({aon, pg}, 2'b10);
        go(1);
        win <= 4'hf;
        ssd <= 2'h2;
        go(12);
        #1;
        chk({aon, pg}, 2'b10);
        go(1);
        u75 <= 4'h4;
        go(12);
        #1;
        chk({aon, e3}, 2'b11);
        go(1);
        u75 <= 4'h0;
        ssd <= 2'h3;
        go(12);
        #1;
        chk({aon, pg}, 2'b11);
        $display("power good test done");
        // Undervoltage latch holds until master cycles
        go(1);
        u75 <= 4'h4;
        go(12);
        #1;
        chk({aon, e3, pg}, 3'b000);
        go(1);
        u75 <= 4'h0;
        go(12);
        #1;
        chk(aon, 1'b0);
        go(1);
        req <= 3'h0;
        go(12);
        req <= 3'h7;
        go(16);
        #1;
        chk({aon, e3}, 2'b11);
        $display("undervoltage test done");
        // Sticky faults from the runs above, then cleared by writing ones
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'hf);
        apb(1'b1, 12'h008, 32'hf);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        $display("fault register test done");
        report_and_stop;
    end
endmodule // power_sequencer_supervisor_tb_top
